//--- hdl/arc_cmp_unit.sv
/*
 * One comparator channel: tests each FIFO output word against the
 * threshold, counts matches and holds the sticky match flag.
 * Assumes settings and words come from logic on the same clock.
 */
`timescale 1ns/10ps

`include "arc_map.svh"

module arc_cmp_unit (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire arc_pkg::arc_cfg_type cfg,
    input  wire arc_pkg::arc_word_type word,
    input  wire logic                flag_clr,
    output logic                     flag,
    output logic                     flag_set
);
    import arc_pkg::*;

    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic       flag_r;
    logic       flag_nxt;
    logic [4:0] target;
    logic       match;
    logic       hit;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        target = {1'b0, cfg.match_count_limit} + 5'h01; // (R4)
        // Samples are two's complement audio, so the test is signed
        if (cfg.condition_select) begin
            match = $signed(word.data) >= $signed(cfg.threshold_value); // (R2)
        end else begin
            match = $signed(word.data) < $signed(cfg.threshold_value); // (R2)
        end
        // Counting stops while the flag is up; the count is held there
        hit = cfg.comparator_enable & word.valid & match & ~flag_r; // (R1) (R7)
        cnt_nxt  = cnt_r;
        flag_nxt = flag_r;
        flag_set = 1'b0;
        if (!cfg.comparator_enable) begin
            cnt_nxt = `ARC_CNT_RST; // (R9)
        end else if (hit) begin
            cnt_nxt = cnt_r + 5'h01; // (R3)
            if (cnt_nxt == target) begin
                flag_nxt = 1'b1; // (R4)
                flag_set = 1'b1;
            end
        end
        // A set in the same cycle as the clear wins
        if (flag_clr) begin
            cnt_nxt = `ARC_CNT_RST; // (R9)
            if (!flag_set) begin
                flag_nxt = 1'b0; // (R5)
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= `ARC_CNT_RST;
            flag_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

endmodule

//--- hdl/arc_map.svh
/*
 * Register map of the ADC result comparator: offsets, field positions
 * and reset values.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH

// Register byte offsets
`define ARC_OFF_CTRL0      8'h18
`define ARC_OFF_CTRL1      8'h1C
`define ARC_OFF_IRQ_STAT   8'h20
`define ARC_OFF_IRQ_MASK   8'h24

// Control register field positions
`define ARC_THR_MSB        31
`define ARC_THR_LSB        16
`define ARC_LIM_MSB        11
`define ARC_LIM_LSB        8
`define ARC_FLAG_BIT       7
`define ARC_COND_BIT       2
`define ARC_IE_BIT         1
`define ARC_EN_BIT         0

// Reset values
`define ARC_CTRL_RST       32'h0000_0000
`define ARC_STAT_RST       2'h0
`define ARC_MASK_RST       2'h3
`define ARC_CNT_RST        5'h00

`endif

//--- hdl/arc_pkg.sv
/*
 * Types shared by the ADC result comparator files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package arc_pkg;

    localparam int ARC_NUM_CMP = 2;

    // Settings of one comparator as software programs them
    typedef struct packed {
        logic [15:0] threshold_value;
        logic [3:0]  match_count_limit;
        logic        condition_select;
        logic        match_irq_enable;
        logic        comparator_enable;
    } arc_cfg_type;

    // One word leaving the ADC FIFO, valid for one cycle
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } arc_word_type;

    typedef logic [ARC_NUM_CMP-1:0] arc_chan_type;

endpackage

//--- hdl/arc_top.sv
/*
 * ADC result comparator: APB register slave, two comparator channels
 * watching the ADC FIFO output, interrupt status and mask.
 * Assumes the FIFO output word and its valid strobe come from logic
 * on pclk, one cycle per word, and a 32-bit APB master on pclk.
 */
`timescale 1ns/10ps

`include "arc_map.svh"

// Summary of operation
// (R1) Each comparator tests every FIFO output word against its 16-bit threshold.
// (R2) Condition bit zero matches below threshold; one matches at or above it.
// (R3) Every matching word adds one to the comparator's match counter while its match flag is clear.
// (R4) Match flag sets when the counter reaches the match count limit plus one.
// (R5) Writing one clears the match flag; writing zero leaves it alone.
// (R6) A flag set with interrupt enable high raises a compare interrupt request; the code drives cmp_irq for it only while that channel's mask bit is set.
// (R7) Compare enable low stops all comparison and matching.
// (R8) A second identical comparator sits one word above the first.
// (R9) Match counter restarts from zero when disabled or when the flag clears.
module arc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire arc_pkg::arc_word_type fifo_word,
    output logic                       cmp_irq
);
    import arc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Bus slave state

    logic [31:0]  prdata_r;
    logic [31:0]  prdata_nxt;
    logic         pready_r;
    logic         pready_nxt;
    logic         pslverr_r;
    logic         pslverr_nxt;

    logic         setup;
    logic         access;
    logic         wr_en;
    logic         sel_ctrl0;
    logic         sel_ctrl1;
    logic         sel_stat;
    logic         sel_mask;
    logic         mapped;

    ////////////////////////////////////////////////////////////////////
    // Comparator and interrupt state

    arc_cfg_type  cfg_r [ARC_NUM_CMP];
    arc_chan_type sel_ctrl;
    arc_chan_type flag_clr;
    arc_chan_type flag;
    arc_chan_type flag_set;

    arc_chan_type stat_r;
    arc_chan_type stat_nxt;
    arc_chan_type mask_r;
    arc_chan_type mask_nxt;
    logic         irq_r;
    logic         irq_nxt;

    ////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb begin
        sel_ctrl0 = 1'b0;
        sel_ctrl1 = 1'b0;
        sel_stat  = 1'b0;
        sel_mask  = 1'b0;
        if (paddr == `ARC_OFF_CTRL0) begin
            sel_ctrl0 = 1'b1;
        end else if (paddr == `ARC_OFF_CTRL1) begin
            sel_ctrl1 = 1'b1; // (R8)
        end else if (paddr == `ARC_OFF_IRQ_STAT) begin
            sel_stat = 1'b1;
        end else if (paddr == `ARC_OFF_IRQ_MASK) begin
            sel_mask = 1'b1;
        end
        mapped   = sel_ctrl0 | sel_ctrl1 | sel_stat | sel_mask;
        sel_ctrl = {sel_ctrl1, sel_ctrl0};
    end

    ////////////////////////////////////////////////////////////////////
    // APB handshake
    // The answer is prepared in the setup cycle, so every transfer
    // completes in its first access cycle with no wait state.

    always_comb begin
        setup  = psel & ~penable;
        access = psel & penable & pready_r;
        wr_en  = access & pwrite & ~pslverr_r;

        pready_nxt  = setup;
        pslverr_nxt = setup & ~mapped;
        prdata_nxt  = prdata_r;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            if (!pwrite && mapped) begin
                if (sel_stat) begin
                    prdata_nxt[ARC_NUM_CMP-1:0] = stat_r;
                end else if (sel_mask) begin
                    prdata_nxt[ARC_NUM_CMP-1:0] = mask_r;
                end else begin
                    for (int i = 0; i < ARC_NUM_CMP; i++) begin
                        if (sel_ctrl[i]) begin
                            prdata_nxt[`ARC_THR_MSB:`ARC_THR_LSB] =
                                cfg_r[i].threshold_value;
                            prdata_nxt[`ARC_LIM_MSB:`ARC_LIM_LSB] =
                                cfg_r[i].match_count_limit;
                            prdata_nxt[`ARC_FLAG_BIT] = flag[i];
                            prdata_nxt[`ARC_COND_BIT] = cfg_r[i].condition_select;
                            prdata_nxt[`ARC_IE_BIT]   = cfg_r[i].match_irq_enable;
                            prdata_nxt[`ARC_EN_BIT]   = cfg_r[i].comparator_enable;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Comparator channels

    generate
        for (genvar g = 0; g < ARC_NUM_CMP; g++) begin : g_cmp
            arc_cfg_type cfg_nxt;
            logic        ctrl_wr;

            always_comb begin
                ctrl_wr = wr_en & sel_ctrl[g];
                cfg_nxt = cfg_r[g];
                if (ctrl_wr) begin
                    cfg_nxt.threshold_value   = pwdata[`ARC_THR_MSB:`ARC_THR_LSB]; // (R1)
                    cfg_nxt.match_count_limit = pwdata[`ARC_LIM_MSB:`ARC_LIM_LSB];
                    cfg_nxt.condition_select  = pwdata[`ARC_COND_BIT]; // (R2)
                    cfg_nxt.match_irq_enable  = pwdata[`ARC_IE_BIT];
                    cfg_nxt.comparator_enable = pwdata[`ARC_EN_BIT]; // (R7)
                end
                // Only a one written to the flag bit clears it
                flag_clr[g] = ctrl_wr & pwdata[`ARC_FLAG_BIT]; // (R5)
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[g] <= arc_cfg_type'(`ARC_CTRL_RST);
                end else begin
                    cfg_r[g] <= cfg_nxt;
                end
            end

            // Both channels see the same word stream independently
            arc_cmp_unit u_cmp ( // (R8)
                .pclk     (pclk),
                .presetn  (presetn),
                .cfg      (cfg_r[g]),
                .word     (fifo_word),
                .flag_clr (flag_clr[g]),
                .flag     (flag[g]),
                .flag_set (flag_set[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output
    // Status records flag events whose channel had its interrupt
    // enabled; the mask is a second gate that resets open.

    always_comb begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_en && sel_stat) begin
            stat_nxt = stat_r & ~pwdata[ARC_NUM_CMP-1:0];
        end
        if (wr_en && sel_mask) begin
            mask_nxt = pwdata[ARC_NUM_CMP-1:0];
        end
        // New events win over a clear written in the same cycle
        for (int i = 0; i < ARC_NUM_CMP; i++) begin
            if (flag_set[i] && cfg_r[i].match_irq_enable) begin
                stat_nxt[i] = 1'b1; // (R6)
            end
        end
        irq_nxt = |(stat_nxt & mask_nxt); // (R6)
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= `ARC_STAT_RST;
            mask_r <= `ARC_MASK_RST;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign cmp_irq = irq_r;

endmodule

//--- tb/arc_fifo_model.sv
/*
 * Word source standing in for the ADC FIFO output.
 * Assumes words are taken on pclk, one per valid pulse.
 */
`timescale 1ns/10ps
////////////////////////////////////////
module arc_fifo_model (
    input  wire logic           pclk,
    output arc_pkg::arc_word_type fifo_word
);
    import arc_pkg::*;
    initial fifo_word = '0;
    // Data flips when idle so a stale word can never look valid
    task automatic push(input logic [15:0] d);
        @(posedge pclk);
        fifo_word <= '{valid: 1'h1, data: d};
        @(posedge pclk);
        fifo_word <= '{valid: 1'h0, data: ~d};
    endtask
endmodule

//--- tb/arc_top_sva.sv
/*
 * Checker on the arc_top ports: APB answer timing and interrupt causes.
 * Assumes one pclk domain; bound to arc_top below.
 */
`timescale 1ns/10ps
////////////////////////////////////////
module arc_top_sva (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic [7:0]            paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire arc_pkg::arc_word_type fifo_word,
    input wire logic                  cmp_irq
);
    import arc_pkg::*;
    logic mapped;
    logic wr_done;
    assign mapped  = paddr inside {8'h18, 8'h1C, 8'h20, 8'h24};
    assign wr_done = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_done; psel && penable && pready; endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (s_done |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (s_setup and !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (s_setup and mapped |=> !pslverr)
        else $error("mapped access refused");
    a_wr_rdzero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on write");
    a_rsvd_zero: assert property (pready && !pwrite && paddr inside {8'h18, 8'h1C}
        |-> prdata[15:12] == 4'h0 && prdata[6:3] == 4'h0)
        else $error("reserved control bits not zero");
    a_irq_cause: assert property ($rose(cmp_irq)
        |-> $past(fifo_word.valid) || $past(wr_done, 2) || $past(wr_done))
        else $error("interrupt without word or write");
    a_irq_drop: assert property ($fell(cmp_irq) |-> $past(wr_done, 2) || $past(wr_done))
        else $error("interrupt dropped without write");
endmodule
bind arc_top arc_top_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_word(fifo_word), .cmp_irq(cmp_irq));

//--- tb/tb.sv
/*
 * Bench for arc_top: APB tasks and comparator scenarios.
 * Assumes arc_fifo_model as word source and the bound checker.
 */
`timescale 1ns/10ps
////////////////////////////////////////
module tb;
    import arc_pkg::*;
    logic         pclk = 1'h0;
    logic         presetn = 1'h0;
    logic [7:0]   paddr = 8'h00;
    logic         psel = 1'h0;
    logic         penable = 1'h0;
    logic         pwrite = 1'h0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    arc_word_type fifo_word;
    logic         cmp_irq;
    int           failures = 0;
    int           checks_done = 0;
    int           cycles = 0;
    logic [31:0]  rd;
    logic         err;
    logic [31:0]  cw;
    logic [7:0]   a;
    always #25 pclk = ~pclk;
    arc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_word(fifo_word), .cmp_irq(cmp_irq));
    arc_fifo_model u_src (.pclk(pclk), .fifo_word(fifo_word));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic irq(input logic exp);
        chk({31'h0, cmp_irq}, {31'h0, exp});
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        paddr  <= ad;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'h1;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic results();
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Ceiling far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        xfer(1'h0, 8'h18, 32'h0); chk(rd, 32'h0);
        xfer(1'h0, 8'h1C, 32'h0); chk(rd, 32'h0);
        xfer(1'h0, 8'h24, 32'h0); chk(rd, 32'h3);
        xfer(1'h0, 8'h40, 32'h0); chk({rd[31:1], err}, 32'h1);
        for (int ch = 0; ch < 2; ch++) for (int c = 0; c < 2; c++) begin
            a  = ch ? 8'h1C : 8'h18;
            cw = {16'h0100, 4'h0, 4'h2, 1'h0, 4'h0, c[0], 2'h3};
            xfer(1'h1, a, cw);
            u_src.push(c ? 16'hFFFF : 16'h0100);
            repeat (2) u_src.push(c ? 16'h0100 : 16'hFF00);
            xfer(1'h0, a, 32'h0); chk(rd, cw);
            u_src.push(c ? 16'h7FFF : 16'h00FF);
            xfer(1'h0, a, 32'h0); chk(rd, cw | 32'h0000_0080);
            xfer(1'h0, a ^ 8'h04, 32'h0); chk({31'h0, rd[7]}, 32'h0);
            xfer(1'h0, 8'h20, 32'h0); chk(rd, 32'h1 << ch);
            irq(1'h1);
            xfer(1'h1, a, cw); xfer(1'h0, a, 32'h0); chk(rd, cw | 32'h0000_0080);
            xfer(1'h1, a, cw | 32'h0000_0080); xfer(1'h0, a, 32'h0); chk(rd, cw);
            xfer(1'h1, 8'h20, 32'h3); xfer(1'h0, 8'h20, 32'h0); chk(rd, 32'h0);
            irq(1'h0);
            xfer(1'h1, a, 32'h0);
        end
        xfer(1'h1, 8'h18, 32'h0100_0000);
        u_src.push(16'h0000);
        xfer(1'h0, 8'h18, 32'h0); chk(rd, 32'h0100_0000);
        cw = 32'h0100_0101;
        xfer(1'h1, 8'h18, cw);
        u_src.push(16'h0000);
        xfer(1'h1, 8'h18, cw & 32'hFFFF_FFFE);
        xfer(1'h1, 8'h18, cw);
        u_src.push(16'h0000);
        xfer(1'h0, 8'h18, 32'h0); chk(rd, cw);
        u_src.push(16'h0000);
        xfer(1'h0, 8'h18, 32'h0); chk(rd, cw | 32'h0000_0080);
        xfer(1'h0, 8'h20, 32'h0); chk(rd, 32'h0);
        xfer(1'h1, 8'h24, 32'h0);
        xfer(1'h1, 8'h1C, 32'h0000_0007);
        u_src.push(16'h0005);
        xfer(1'h0, 8'h20, 32'h0); chk(rd, 32'h2);
        irq(1'h0);
        xfer(1'h1, 8'h24, 32'h3); xfer(1'h0, 8'h24, 32'h0); chk(rd, 32'h3);
        irq(1'h1);
        xfer(1'h1, 8'h20, 32'h2); xfer(1'h0, 8'h20, 32'h0); chk(rd, 32'h0);
        irq(1'h0);
        results();
    end
endmodule
